// File: core/art_timer.sv
`timescale 1ns/10ps
`default_nettype none

module art_timer
  import art_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        timer_timebase,
  input  wire logic        trigger_direction_input,
  input  wire logic        count_pin_i,
  output var  logic        count_pin_o,
  output var  logic        count_pin_oe_n,
  input  wire logic        first_timer_overflow,
  input  wire logic        second_timer_overflow,
  input  wire logic        first_port_latch,
  input  wire logic        second_port_latch,
  output var  logic        first_timer_pin_o,
  output var  logic        second_timer_pin_o,
  output var  art_baud_t   baud_tick,
  output var  logic        timer_irq_req
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic trig_level, trig_fall;
  logic cnt_level_unused, cnt_fall;

  art_pin_sync u_trig_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_i   (trigger_direction_input),
    .level   (trig_level),
    .fall    (trig_fall)
  );

  art_pin_sync u_count_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_i   (count_pin_i),
    .level   (cnt_level_unused),
    .fall    (cnt_fall)
  );

  // ****************************************
  // Bus slave state
  // ****************************************
  logic [11:0] addr_q, addr_d;
  logic        wr_pend_q, wr_pend_d;
  logic        rd_pend_q, rd_pend_d;
  logic        ready_q, ready_d;
  logic [31:0] rdata_q, rdata_d;
  logic        hit;
  logic        take;

  // ****************************************
  // Timer state
  // ****************************************
  art_ctrl_t   ctrl_q, ctrl_d;
  art_mode_t   mode_q, mode_d;
  logic [7:0]  osel_q, osel_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cap_q, cap_d;
  logic [15:0] rld_q, rld_d;
  logic        clk_out_q, clk_out_d;
  logic        oe_n_q, oe_n_d;
  logic        tog0_q, tog0_d;
  logic        tog1_q, tog1_d;
  logic        pin0_q, pin0_d;
  logic        pin1_q, pin1_d;
  art_baud_t   baud_q, baud_d;
  logic        irq_q, irq_d;

  art_op_t     op;
  logic        tick;
  logic        roll;
  logic        ext_set;
  logic        ext_tog;
  logic        clkout_mode;

  function automatic logic [31:0] read_word(input logic [11:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      ART_IDX_OUTSEL:  w = {24'h00_0000, osel_q};
      ART_IDX_CTRL:    w = {24'h00_0000, ctrl_q};
      ART_IDX_MODE:    w = {24'h00_0000, mode_q};
      ART_IDX_COUNT:   w = {16'h0000, cnt_q};
      ART_IDX_CAPTURE: w = {16'h0000, cap_q};
      ART_IDX_RELOAD:  w = {16'h0000, rld_q};
      default:         w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ****************************************
  // AHB-Lite slave: writes take effect at the end of the
  // data phase, reads add one wait state so a read that
  // directly follows a write sees the written value
  // ****************************************
  assign take = hsel & htrans[1] & hready;
  assign hit  = (haddr[31:14] == 18'h0_0000);

  always_comb begin
    addr_d    = addr_q;
    wr_pend_d = 1'b0;
    rd_pend_d = 1'b0;
    ready_d   = 1'b1;
    rdata_d   = rdata_q;
    if (rd_pend_q) begin
      rdata_d = read_word(addr_q);
    end
    if (take) begin
      addr_d    = hit ? haddr[13:2] : 12'h000;
      wr_pend_d = hwrite;
      rd_pend_d = ~hwrite;
      ready_d   = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 12'h000;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q   <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else begin
      addr_q    <= addr_d;
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      ready_q   <= ready_d;
      rdata_q   <= rdata_d;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb begin
    if (!ctrl_q.aux_run_bit) begin
      op = ART_OP_STOP;
    end else if (ctrl_q.uart0_receive_clock_select | ctrl_q.uart0_transmit_clock_select |
                 mode_q.uart1_receive_clock_select | mode_q.uart1_transmit_clock_select) begin
      op = ART_OP_BAUD;
    end else if (ctrl_q.capture_reload_select) begin
      op = ART_OP_CAPTURE;
    end else if (mode_q.down_count_enable) begin
      op = ART_OP_UPDOWN;
    end else begin
      op = ART_OP_RELOAD;
    end
  end

  // Clock-out needs the internal source; the pin is then an output
  assign clkout_mode = mode_q.clock_out_enable & ~ctrl_q.counter_source_select;

  // Baud generation ignores the source select and counts the timebase
  always_comb begin
    if (op == ART_OP_BAUD) begin
      tick = timer_timebase;
    end else begin
      tick = ctrl_q.counter_source_select ? cnt_fall : timer_timebase;
    end
  end

  // ****************************************
  // Counter next state
  // ****************************************
  always_comb begin
    cnt_d   = cnt_q;
    cap_d   = cap_q;
    roll    = 1'b0;
    ext_set = 1'b0;
    ext_tog = 1'b0;
    case (op)
      ART_OP_CAPTURE: begin
        if (tick) begin
          cnt_d = cnt_q + ART_COUNT_STEP;
          roll  = (cnt_q == ART_COUNT_MAX);
        end
        if (trig_fall && ctrl_q.external_trigger_enable) begin
          cap_d   = cnt_q;
          ext_set = 1'b1;
        end
      end
      ART_OP_RELOAD: begin
        if (tick) begin
          if (cnt_q == ART_COUNT_MAX) begin
            cnt_d = rld_q;
            roll  = 1'b1;
          end else begin
            cnt_d = cnt_q + ART_COUNT_STEP;
          end
        end
        if (trig_fall && ctrl_q.external_trigger_enable) begin
          cnt_d   = rld_q;
          ext_set = 1'b1;
        end
      end
      ART_OP_UPDOWN: begin
        // The trigger pin steers direction here, so its edges cause nothing
        if (tick) begin
          if (trig_level) begin
            if (cnt_q == ART_COUNT_MAX) begin
              cnt_d = rld_q;
              roll  = 1'b1;
            end else begin
              cnt_d = cnt_q + ART_COUNT_STEP;
            end
          end else if (cnt_q == rld_q) begin
            cnt_d = ART_COUNT_MAX;
            roll  = 1'b1;
          end else begin
            cnt_d = cnt_q - ART_COUNT_STEP;
          end
        end
        ext_tog = roll;
      end
      ART_OP_BAUD: begin
        if (tick) begin
          if (cnt_q == ART_COUNT_MAX) begin
            cnt_d = rld_q;
            roll  = 1'b1;
          end else begin
            cnt_d = cnt_q + ART_COUNT_STEP;
          end
        end
        if (trig_fall && ctrl_q.external_trigger_enable) begin
          ext_set = 1'b1;
        end
      end
      default: cnt_d = cnt_q;
    endcase
    // A software write to the count beats the same cycle's count step
    if (wr_pend_q && (addr_q == ART_IDX_COUNT)) begin
      cnt_d = hwdata[15:0];
    end
  end

  // ****************************************
  // Registers, flags and outputs next state
  // ****************************************
  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    osel_d = osel_q;
    rld_d  = rld_q;
    if (wr_pend_q) begin
      case (addr_q)
        ART_IDX_CTRL:   ctrl_d = art_ctrl_t'(hwdata[7:0]);
        ART_IDX_MODE:   mode_d = art_mode_t'(hwdata[7:0] & ART_MODE_MASK);
        ART_IDX_OUTSEL: osel_d = hwdata[7:0] & ART_OSEL_MASK;
        ART_IDX_RELOAD: rld_d  = hwdata[15:0];
        default:        rld_d  = rld_q;
      endcase
    end
    // Hardware events are applied after a software write, so a set wins
    if (roll && (op != ART_OP_BAUD) && !clkout_mode) begin
      ctrl_d.main_overflow_flag = 1'b1;
    end
    if (ext_tog) begin
      ctrl_d.external_edge_flag = ~ctrl_d.external_edge_flag;
    end
    if (ext_set) begin
      ctrl_d.external_edge_flag = 1'b1;
    end

    // Toggle per roll gives half a period of (65536 - reload) ticks
    clk_out_d = (clkout_mode && roll) ? ~clk_out_q : clk_out_q;
    oe_n_d    = ~clkout_mode;

    baud_d.uart0_tx = roll && (op == ART_OP_BAUD) && ctrl_q.uart0_transmit_clock_select;
    baud_d.uart0_rx = roll && (op == ART_OP_BAUD) && ctrl_q.uart0_receive_clock_select;
    baud_d.uart1_tx = roll && (op == ART_OP_BAUD) && mode_q.uart1_transmit_clock_select;
    baud_d.uart1_rx = roll && (op == ART_OP_BAUD) && mode_q.uart1_receive_clock_select;

    // Edge flag in up/down operation is a count bit, not a request
    irq_d = ctrl_d.main_overflow_flag |
            (ctrl_d.external_edge_flag & (op != ART_OP_UPDOWN));

    tog0_d = tog0_q ^ first_timer_overflow;
    tog1_d = tog1_q ^ second_timer_overflow;
    pin0_d = osel_q[ART_OSEL_FIRST_BIT]  ? tog0_q : first_port_latch;
    pin1_d = osel_q[ART_OSEL_SECOND_BIT] ? tog1_q : second_port_latch;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= art_ctrl_t'(ART_RST_BYTE);
      mode_q    <= art_mode_t'(ART_RST_BYTE);
      osel_q    <= ART_RST_BYTE;
      cnt_q     <= ART_RST_WORD;
      cap_q     <= ART_RST_WORD;
      rld_q     <= ART_RST_WORD;
      clk_out_q <= 1'b0;
      oe_n_q    <= 1'b1;
      tog0_q    <= 1'b0;
      tog1_q    <= 1'b0;
      pin0_q    <= 1'b0;
      pin1_q    <= 1'b0;
      baud_q    <= '0;
      irq_q     <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      mode_q    <= mode_d;
      osel_q    <= osel_d;
      cnt_q     <= cnt_d;
      cap_q     <= cap_d;
      rld_q     <= rld_d;
      clk_out_q <= clk_out_d;
      oe_n_q    <= oe_n_d;
      tog0_q    <= tog0_d;
      tog1_q    <= tog1_d;
      pin0_q    <= pin0_d;
      pin1_q    <= pin1_d;
      baud_q    <= baud_d;
      irq_q     <= irq_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hrdata             = rdata_q;
  assign hreadyout          = ready_q;
  assign hresp              = 1'b0;
  assign count_pin_o        = clk_out_q;
  assign count_pin_oe_n     = oe_n_q;
  assign first_timer_pin_o  = pin0_q;
  assign second_timer_pin_o = pin1_q;
  assign baud_tick          = baud_q;
  assign timer_irq_req      = irq_q;

endmodule // art_timer

`default_nettype wire

// File: pkg/art_pkg.sv
`default_nettype none

package art_pkg;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [11:0] ART_IDX_OUTSEL  = 12'h411;
  localparam logic [11:0] ART_IDX_CTRL    = 12'h418;
  localparam logic [11:0] ART_IDX_MODE    = 12'h419;
  localparam logic [11:0] ART_IDX_COUNT   = 12'h41A;
  localparam logic [11:0] ART_IDX_CAPTURE = 12'h41B;
  localparam logic [11:0] ART_IDX_RELOAD  = 12'h41C;

  // ****************************************
  // Field positions, masks and reset values
  // ****************************************
  localparam int unsigned ART_OSEL_FIRST_BIT  = 0;
  localparam int unsigned ART_OSEL_SECOND_BIT = 2;
  localparam logic [7:0]  ART_OSEL_MASK       = 8'h05;
  localparam logic [7:0]  ART_MODE_MASK       = 8'h33;
  localparam logic [7:0]  ART_RST_BYTE        = 8'h00;
  localparam logic [15:0] ART_RST_WORD        = 16'h0000;
  localparam logic [15:0] ART_COUNT_MAX       = 16'hFFFF;
  localparam logic [15:0] ART_COUNT_STEP      = 16'h0001;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic main_overflow_flag;
    logic external_edge_flag;
    logic uart0_receive_clock_select;
    logic uart0_transmit_clock_select;
    logic external_trigger_enable;
    logic aux_run_bit;
    logic counter_source_select;
    logic capture_reload_select;
  } art_ctrl_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       uart1_receive_clock_select;
    logic       uart1_transmit_clock_select;
    logic [1:0] rsv_lo;
    logic       clock_out_enable;
    logic       down_count_enable;
  } art_mode_t;

  typedef struct packed {
    logic uart0_tx;
    logic uart0_rx;
    logic uart1_tx;
    logic uart1_rx;
  } art_baud_t;

  typedef enum logic [2:0] {
    ART_OP_STOP,
    ART_OP_RELOAD,
    ART_OP_UPDOWN,
    ART_OP_CAPTURE,
    ART_OP_BAUD
  } art_op_t;

endpackage

`default_nettype wire

// File: core/art_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module art_pin_sync
  import art_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_i,
  output var  logic level,
  output var  logic fall
);

  logic s1_q, s2_q, s3_q;
  logic level_q, level_d;
  logic fall_q, fall_d;

  // ****************************************
  // Three-stage synchroniser, accept on agreement
  // ****************************************
  always_comb begin
    level_d = level_q;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
    fall_d = level_q & ~level_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
      fall_q  <= 1'b0;
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
      fall_q  <= fall_d;
    end
  end

  assign level = level_q;
  assign fall  = fall_q;

endmodule // art_pin_sync

`default_nettype wire

// File: verification/art_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none

module art_timer_sva
  import art_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timer_timebase,
  input wire logic        count_pin_o,
  input wire logic        count_pin_oe_n,
  input wire art_baud_t   baud_tick,
  input wire logic        timer_irq_req
);
  // ****
  // Bus and timer checks
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait cycle wrong");
  a_write_ready: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  a_reset_quiet: assert property (!$past(hresetn) |-> !timer_irq_req && count_pin_oe_n && baud_tick == '0)
    else $error("outputs active after reset");
  a_baud_timebase: assert property (|baud_tick |-> $past(timer_timebase) || $past(timer_timebase, 2))
    else $error("baud tick without timebase tick");
  a_clkout_step: assert property (!count_pin_oe_n && $changed(count_pin_o) |->
    $past(timer_timebase) || $past(timer_timebase, 2))
    else $error("clock out toggled without tick");
  a_clkout_quiet: assert property (!count_pin_oe_n && !$past(count_pin_oe_n) |-> !$rose(timer_irq_req))
    else $error("interrupt in clock out mode");
endmodule // art_timer_sva

`default_nettype wire

// File: verification/art_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

module art_pin_model (
  input  wire logic hclk,
  input  wire logic trig_level,
  input  wire logic ev_level,
  input  wire logic count_pin_o,
  input  wire logic count_pin_oe_n,
  output wire logic trigger_direction_input,
  output wire logic count_pin_i,
  output var  int   toggles
);
  logic last_q;
  int   tog_q = 0;

  assign trigger_direction_input = trig_level;
  // Shared pin: the device wins while it drives, else the event source
  assign count_pin_i = count_pin_oe_n ? ev_level : count_pin_o;

  assign toggles = tog_q;
  always @(posedge hclk) begin
    if (!count_pin_oe_n && count_pin_o !== last_q) tog_q <= tog_q + 1;
    last_q <= count_pin_o;
  end
endmodule // art_pin_model

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("FAIL %0t %h vs %h", $time, g, e); end end

module testbench;
  import art_pkg::*;
  localparam logic [13:0] A_OSEL = {ART_IDX_OUTSEL, 2'h0};
  localparam logic [13:0] A_CTRL = {ART_IDX_CTRL, 2'h0};
  localparam logic [13:0] A_MODE = {ART_IDX_MODE, 2'h0};
  localparam logic [13:0] A_CNT  = {ART_IDX_COUNT, 2'h0};
  localparam logic [13:0] A_CAP  = {ART_IDX_CAPTURE, 2'h0};
  localparam logic [13:0] A_REL  = {ART_IDX_RELOAD, 2'h0};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        timer_timebase = 1'b0;
  logic        trig_level = 1'b1;
  logic        ev_level = 1'b1;
  logic        first_timer_overflow = 1'b0;
  logic        first_port_latch = 1'b0;
  logic        second_timer_overflow = 1'b0;
  logic        second_port_latch = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rd_q;
  logic        hreadyout;
  logic        hresp;
  logic        trigger_direction_input;
  logic        count_pin_i;
  logic        count_pin_o;
  logic        count_pin_oe_n;
  logic        first_timer_pin_o;
  logic        second_timer_pin_o;
  art_baud_t   baud_tick;
  logic        timer_irq_req;
  int          fails = 0;
  int          checks_done = 0;
  int          toggles;

  always #4 hclk = ~hclk;

  art_timer i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .timer_timebase(timer_timebase), .trigger_direction_input(trigger_direction_input),
    .count_pin_i(count_pin_i), .count_pin_o(count_pin_o), .count_pin_oe_n(count_pin_oe_n),
    .first_timer_overflow(first_timer_overflow), .second_timer_overflow(second_timer_overflow),
    .first_port_latch(first_port_latch), .second_port_latch(second_port_latch),
    .first_timer_pin_o(first_timer_pin_o),
    .second_timer_pin_o(second_timer_pin_o), .baud_tick(baud_tick), .timer_irq_req(timer_irq_req)
  );

  art_pin_model i_pins (
    .hclk(hclk), .trig_level(trig_level), .ev_level(ev_level), .count_pin_o(count_pin_o),
    .count_pin_oe_n(count_pin_oe_n), .trigger_direction_input(trigger_direction_input),
    .count_pin_i(count_pin_i), .toggles(toggles)
  );

  // ****
  // Bus and helper tasks
  // ****
  task automatic give_verdict;
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Ready and read data are taken as sampled at the rising edge
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    d = hrdata;
    if (hreadyout !== 1'b1) begin
      fails++;
      give_verdict;
    end
  endtask

  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {18'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(rd_q);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd_q);
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [13:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd_q, e)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic ticks(input int n);
    timer_timebase <= 1'b1;
    idle(n);
    timer_timebase <= 1'b0;
    idle(2);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    logic [13:0] regs [7] = '{A_OSEL, A_CTRL, A_MODE, A_CNT, A_CAP, A_REL, 14'h0};
    wr(14'h0, 32'hFFFFFFFF);
    wr(A_CAP, 32'h5555);
    foreach (regs[i]) rchk(regs[i], 32'h0);
    `CHK(count_pin_oe_n, 1'b1)
  endtask

  task automatic t_reload;
    wr(A_REL, 32'h1234);
    wr(A_CNT, 32'hFFFF);
    wr(A_CTRL, 32'h04);
    ticks(1);
    `CHK(timer_irq_req, 1'b1)
    rchk(A_CNT, 32'h1234);
    rchk(A_CTRL, 32'h84);
    ticks(2);
    rchk(A_CNT, 32'h1236);
    rchk(A_CTRL, 32'h84);
    wr(A_CTRL, 32'h00);
    idle(2);
    `CHK(timer_irq_req, 1'b0)
  endtask

  task automatic t_trigger(input logic [31:0] ctl, input logic [31:0] cnt, input logic [31:0] cap,
                           input logic [31:0] ectl);
    wr(A_CNT, 32'h00AB);
    wr(A_CTRL, ctl);
    trig_level <= 1'b0;
    idle(6);
    trig_level <= 1'b1;
    idle(6);
    rchk(A_CNT, cnt);
    rchk(A_CAP, cap);
    rchk(A_CTRL, ectl);
    `CHK(timer_irq_req, ectl[6])
    wr(A_CTRL, 32'h00);
  endtask

  task automatic t_updown;
    wr(A_MODE, 32'h01);
    wr(A_REL, 32'h0010);
    wr(A_CNT, 32'h0011);
    wr(A_CTRL, 32'h04);
    trig_level <= 1'b0;
    idle(6);
    ticks(1);
    rchk(A_CNT, 32'h0010);
    ticks(1);
    rchk(A_CNT, 32'hFFFF);
    rchk(A_CTRL, 32'hC4);
    wr(A_CTRL, 32'h44);
    idle(2);
    `CHK(timer_irq_req, 1'b0)
    trig_level <= 1'b1;
    idle(6);
    ticks(1);
    rchk(A_CNT, 32'h0010);
    rchk(A_CTRL, 32'h84);
    wr(A_CTRL, 32'h00);
    wr(A_MODE, 32'h00);
  endtask

  task automatic t_clkout(input logic [31:0] ctl, input logic [31:0] md);
    int b;
    int u;
    int t0;
    int ov;
    b = 0;
    u = 0;
    ov = 16 / (65536 - 32'hFFFE);
    wr(A_REL, 32'hFFFE);
    wr(A_CNT, 32'hFFFE);
    wr(A_MODE, md);
    wr(A_CTRL, ctl);
    t0 = toggles;
    for (int i = 0; i < 20; i++) begin
      timer_timebase <= (i < 16) ? 1'b1 : 1'b0;
      @(negedge hclk);
      b += baud_tick.uart0_tx;
      u += baud_tick.uart1_rx;
      @(posedge hclk);
    end
    `CHK(toggles - t0, ov)
    `CHK(b, ctl[4] ? ov : 0)
    `CHK(u, md[5] ? ov : 0)
    `CHK(count_pin_oe_n, 1'b0)
    `CHK(timer_irq_req, 1'b0)
    rchk(A_CTRL, ctl);
    rchk(A_MODE, md);
    wr(A_CTRL, 32'h00);
    wr(A_MODE, 32'h00);
  endtask

  task automatic t_event;
    wr(A_CNT, 32'h0000);
    wr(A_CTRL, 32'h06);
    timer_timebase <= 1'b1;
    repeat (3) begin
      ev_level <= 1'b0;
      idle(6);
      ev_level <= 1'b1;
      idle(6);
    end
    timer_timebase <= 1'b0;
    rchk(A_CNT, 32'h0003);
    wr(A_CTRL, 32'h00);
  endtask

  task automatic t_outsel;
    first_port_latch  <= 1'b1;
    second_port_latch <= 1'b1;
    idle(2);
    `CHK({first_timer_pin_o, second_timer_pin_o}, 2'h3)
    wr(A_OSEL, 32'hFF);
    rchk(A_OSEL, 32'h05);
    `CHK({first_timer_pin_o, second_timer_pin_o}, 2'h0)
    first_timer_overflow <= 1'b1;
    idle(1);
    first_timer_overflow <= 1'b0;
    idle(2);
    `CHK({first_timer_pin_o, second_timer_pin_o}, 2'h2)
    second_timer_overflow <= 1'b1;
    idle(1);
    second_timer_overflow <= 1'b0;
    idle(2);
    `CHK({first_timer_pin_o, second_timer_pin_o}, 2'h3)
  endtask

  initial begin
    idle(12);
    hresetn <= 1'b1;
    idle(1);
    t_reset;
    t_reload;
    t_trigger(32'h05, 32'h00AB, 32'h0000, 32'h05);
    t_trigger(32'h0D, 32'h00AB, 32'h00AB, 32'h4D);
    t_trigger(32'h0C, 32'h1234, 32'h00AB, 32'h4C);
    t_updown;
    t_clkout(32'h04, 32'h02);
    t_clkout(32'h14, 32'h02);
    t_clkout(32'h04, 32'h22);
    t_event;
    t_outsel;
    give_verdict;
  end
endmodule // testbench

bind art_timer art_timer_sva i_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_timebase(timer_timebase),
  .count_pin_o(count_pin_o), .count_pin_oe_n(count_pin_oe_n), .baud_tick(baud_tick),
  .timer_irq_req(timer_irq_req)
);

`default_nettype wire
